/* design/pxts_consts.vh */
/*
 * constants for the protected exception and task switch controller.
 * assumes: included by the design file by bare name.
 */
`ifndef PXTS_CONSTS_VH
`define PXTS_CONSTS_VH
// =====================================================
// vectors
`define PXTS_VEC_CPX_NA 8'h07
`define PXTS_VEC_DBL 8'h08
`define PXTS_VEC_CPX_OVR 8'h09
`define PXTS_VEC_BAD_TSS 8'h0A
`define PXTS_VEC_NP 8'h0B
`define PXTS_VEC_STACK 8'h0C
`define PXTS_VEC_GP 8'h0D
// =====================================================
// descriptor and flag layout
`define PXTS_TSS_MIN_LIMIT 16'h002B
`define PXTS_TYPE_AVAIL 4'h1
`define PXTS_TYPE_BUSY 4'h3
`define PXTS_NT_BIT 14
`define PXTS_RPL_MSB 1
`define PXTS_ZERO_CODE 16'h0000
// =====================================================
// stack wrap pointers
`define PXTS_SP_W0 16'h0000
`define PXTS_SP_W1 16'h0001
`define PXTS_SP_W2 16'hFFFE
`define PXTS_SP_W3 16'hFFFF
// =====================================================
// reset entry point
`define PXTS_RST_CS 16'hF000
`define PXTS_RST_IP 16'hFFF0
// =====================================================
// task switch sources
`define PXTS_SRC_JMP 2'h0
`define PXTS_SRC_CALL 2'h1
`define PXTS_SRC_INT 2'h2
`define PXTS_SRC_INTERRUPT_RETURN_OP 2'h3
// =====================================================
// pointer test ops
`define PXTS_PT_VERIFY_READABLE_OP 3'h0
`define PXTS_PT_VERIFY_WRITABLE_OP 3'h1
`define PXTS_PT_LSL 3'h2
`define PXTS_PT_LAR 3'h3
`define PXTS_PT_ADJUST_PRIVILEGE_OP 3'h4
`endif

/* design/pxts_ctrl.v */
/*
 * protected-mode exception vectoring, task switch bookkeeping,
 * pointer test flags, double fault/shutdown and reset addressing.
 * assumes: the instruction sequencer presents one-cycle event strobes,
 * descriptor lookups are done outside and their results arrive as
 * inputs synchronous to i_sys_clk.
 */
// Operation
// - push selector error code, zero if none
// - return address at faulting instruction, prefixes
// - overrun vectors 9, no code, not restartable
// - vectors 8,10,11,12,13 push error code
// - not present gives 11 or 12, restartable
// - push/pop-all wrap flagged by saved pointer
// - jump, call, gate interrupt start switch
// - switch saves old state, loads new task
// - segment limit must exceed 002B hex
// - new selector reloads hidden base and limit
// - nested flag bit 14 selects return kind
// - mark busy, set back link, not old on jump
// - call/interrupt switch sets nested, plain interrupt clears
// - busy is type 3; busy use gives 13
// - every switch sets task-switched flag
// - escape/wait with both flags faults 7
// - pointer tests set zero flag if permitted
// - adjust privilege: max field, zero if changed
// - second exception double faults, third shuts down
// - shutdown halt cycle; nmi or reset exits
// - high address nibble until code segment changes
// - reset entry F000:FFF0
`timescale 1ns/10ps
`include "pxts_consts.vh"
module pxts_ctrl #(
  parameter SEL_W = 16
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_ce,
  // exception sources
  input wire i_exc_req,
  input wire [7:0] i_exc_vec,
  input wire [SEL_W-1:0] i_exc_sel,
  input wire i_exc_sel_valid,
  input wire i_exc_stack_seg,
  input wire [15:0] i_insn_start_ip,
  input wire [15:0] i_next_ip,
  input wire i_insn_done,
  input wire i_nmi,
  input wire i_push_all_op_pop_all_op,
  input wire [15:0] i_saved_sp,
  input wire i_cpx_op,
  // task switch
  input wire i_ts_req,
  input wire [1:0] i_ts_src,
  input wire i_ts_gate_is_task,
  input wire [SEL_W-1:0] i_ts_new_sel,
  input wire [15:0] i_ts_new_limit,
  input wire [23:0] i_ts_new_base,
  input wire [3:0] i_ts_new_type,
  input wire [15:0] i_ts_new_flags,
  input wire i_int_no_switch,
  input wire i_flag_write,
  input wire [15:0] i_flag_wdata,
  input wire i_msw_write,
  input wire [3:0] i_msw_wdata,
  // pointer tests
  input wire i_pt_req,
  input wire [2:0] i_pt_op,
  input wire i_pt_permit,
  input wire [1:0] i_pt_sel_rpl,
  input wire [1:0] i_pt_reg_rpl,
  // code segment load
  input wire i_cs_load,
  // outputs
  output reg o_exc_take,
  output reg [7:0] o_exc_vec,
  output reg o_err_push,
  output reg [15:0] o_err_code,
  output reg [15:0] o_ret_ip,
  output reg o_restartable,
  output reg o_ts_accept,
  output reg o_ts_save_old,
  output reg o_ts_mark_old_busy,
  output reg o_ts_mark_old_free,
  output reg o_ts_mark_new_busy,
  output reg [3:0] o_ts_new_type,
  output reg [SEL_W-1:0] o_back_link,
  output reg [SEL_W-1:0] o_task_sel,
  output reg [23:0] o_task_base,
  output reg [15:0] o_task_limit,
  output reg o_nested_task_flag,
  output reg o_interrupt_return_op_switch,
  output reg o_task_switched_flag,
  output reg o_coprocessor_present_flag,
  output reg o_protect_enable_flag,
  output reg o_zero_result_flag,
  output reg [1:0] o_adj_rpl,
  output reg o_shutdown,
  output reg o_halt_cycle,
  output reg o_addr1,
  output reg o_addr_hi_force,
  output reg [15:0] o_cs,
  output reg [15:0] o_ip
);
  // =====================================================
  // helpers
  function has_code;
    input [7:0] v;
    begin
      has_code = (v == `PXTS_VEC_DBL) || (v == `PXTS_VEC_BAD_TSS) ||
        (v == `PXTS_VEC_NP) || (v == `PXTS_VEC_STACK) ||
        (v == `PXTS_VEC_GP);
    end
  endfunction

  function sp_wrapped;
    input [15:0] sp;
    begin
      sp_wrapped = (sp == `PXTS_SP_W0) || (sp == `PXTS_SP_W1) ||
        (sp == `PXTS_SP_W2) || (sp == `PXTS_SP_W3);
    end
  endfunction

  // =====================================================
  // exception state: one-hot
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_DBL = 3'h2;
  localparam [2:0] ST_SHUT = 3'h4;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg in_insn_exc_q;
  reg [7:0] vec_eff;
  wire cpx_fault;
  wire any_exc;
  wire busy_use;
  wire ts_go;

  // busy target or short limit refuses the switch
  assign busy_use = i_ts_req && (i_ts_src != `PXTS_SRC_INTERRUPT_RETURN_OP) &&
    (i_ts_new_type == `PXTS_TYPE_BUSY);
  assign ts_go = i_ts_req && !busy_use &&
    (i_ts_new_limit > `PXTS_TSS_MIN_LIMIT) &&
    (i_ts_src != `PXTS_SRC_INT || i_ts_gate_is_task);
  assign cpx_fault = i_cpx_op && o_task_switched_flag &&
    o_coprocessor_present_flag;
  assign any_exc = i_exc_req || cpx_fault || busy_use;

  always @* begin
    if (busy_use)
      vec_eff = `PXTS_VEC_GP;
    else if (cpx_fault)
      vec_eff = `PXTS_VEC_CPX_NA;
    else if (i_exc_vec == `PXTS_VEC_NP && i_exc_stack_seg)
      vec_eff = `PXTS_VEC_STACK;
    else
      vec_eff = i_exc_vec;
  end

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: if (any_exc && in_insn_exc_q) st_d = ST_DBL;
      ST_DBL: begin
        if (any_exc) st_d = ST_SHUT;
        else if (i_insn_done) st_d = ST_RUN;
      end
      ST_SHUT: if (i_nmi) st_d = ST_RUN;
      default: st_d = ST_RUN;
    endcase
  end

  // =====================================================
  // sequential
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_RUN;
      in_insn_exc_q <= 1'b0;
      o_exc_take <= 1'b0;
      o_exc_vec <= 8'h00;
      o_err_push <= 1'b0;
      o_err_code <= `PXTS_ZERO_CODE;
      o_ret_ip <= 16'h0000;
      o_restartable <= 1'b0;
      o_ts_accept <= 1'b0;
      o_ts_save_old <= 1'b0;
      o_ts_mark_old_busy <= 1'b0;
      o_ts_mark_old_free <= 1'b0;
      o_ts_mark_new_busy <= 1'b0;
      o_ts_new_type <= `PXTS_TYPE_AVAIL;
      o_back_link <= {SEL_W{1'b0}};
      o_task_sel <= {SEL_W{1'b0}};
      o_task_base <= 24'h000000;
      o_task_limit <= 16'h0000;
      o_nested_task_flag <= 1'b0;
      o_interrupt_return_op_switch <= 1'b0;
      o_task_switched_flag <= 1'b0;
      o_coprocessor_present_flag <= 1'b0;
      o_protect_enable_flag <= 1'b0;
      o_zero_result_flag <= 1'b0;
      o_adj_rpl <= 2'h0;
      o_shutdown <= 1'b0;
      o_halt_cycle <= 1'b0;
      o_addr1 <= 1'b1;
      o_addr_hi_force <= 1'b1;
      o_cs <= `PXTS_RST_CS;
      o_ip <= `PXTS_RST_IP;
    end else if (i_ce) begin
      st_q <= st_d;
      o_exc_take <= 1'b0;
      o_ts_accept <= 1'b0;
      o_ts_save_old <= 1'b0;
      o_ts_mark_old_busy <= 1'b0;
      o_ts_mark_old_free <= 1'b0;
      o_ts_mark_new_busy <= 1'b0;
      o_interrupt_return_op_switch <= 1'b0;
      o_halt_cycle <= 1'b0;
      o_shutdown <= (st_d == ST_SHUT);
      if (i_insn_done)
        in_insn_exc_q <= 1'b0;
      // -------- exceptions; none taken in shutdown
      if (any_exc && st_q == ST_RUN) begin
        in_insn_exc_q <= 1'b1;
        o_exc_take <= 1'b1;
        o_exc_vec <= in_insn_exc_q ? `PXTS_VEC_DBL : vec_eff;
        o_err_push <= in_insn_exc_q || has_code(vec_eff);
        // busy target: the selector involved is the refused one
        if (busy_use && !in_insn_exc_q)
          o_err_code <= i_ts_new_sel;
        else
          o_err_code <= (!in_insn_exc_q && i_exc_sel_valid && !cpx_fault) ?
            i_exc_sel : `PXTS_ZERO_CODE;
        // overrun reports the following ip, not the escape op
        o_ret_ip <= (vec_eff == `PXTS_VEC_CPX_OVR && !in_insn_exc_q) ?
          i_next_ip : i_insn_start_ip;
        o_restartable <= !in_insn_exc_q &&
          (vec_eff == `PXTS_VEC_BAD_TSS || vec_eff == `PXTS_VEC_NP ||
          (vec_eff == `PXTS_VEC_STACK &&
          !(i_push_all_op_pop_all_op && sp_wrapped(i_saved_sp))));
        if (vec_eff != `PXTS_VEC_DBL && !i_ts_req &&
          !i_int_no_switch && !in_insn_exc_q)
          o_nested_task_flag <= o_nested_task_flag;
      end
      if (st_d == ST_SHUT && st_q != ST_SHUT) begin
        o_halt_cycle <= 1'b1;
        o_addr1 <= 1'b0;
      end else if (st_q != ST_SHUT)
        o_addr1 <= 1'b1;
      // -------- task switch
      if (ts_go && st_q == ST_RUN && !any_exc) begin
        o_ts_accept <= 1'b1;
        o_ts_save_old <= 1'b1;
        o_ts_mark_new_busy <= (i_ts_src != `PXTS_SRC_INTERRUPT_RETURN_OP);
        o_ts_new_type <= `PXTS_TYPE_BUSY;
        o_ts_mark_old_busy <= (i_ts_src == `PXTS_SRC_CALL) ||
          (i_ts_src == `PXTS_SRC_INT);
        o_ts_mark_old_free <= (i_ts_src == `PXTS_SRC_JMP) ||
          (i_ts_src == `PXTS_SRC_INTERRUPT_RETURN_OP);
        if (i_ts_src != `PXTS_SRC_INTERRUPT_RETURN_OP)
          o_back_link <= o_task_sel;
        o_task_sel <= i_ts_new_sel;
        o_task_base <= i_ts_new_base;
        o_task_limit <= i_ts_new_limit;
        o_nested_task_flag <= (i_ts_src == `PXTS_SRC_CALL) ||
          (i_ts_src == `PXTS_SRC_INT) ||
          i_ts_new_flags[`PXTS_NT_BIT];
        o_interrupt_return_op_switch <= (i_ts_src == `PXTS_SRC_INTERRUPT_RETURN_OP);
        o_task_switched_flag <= 1'b1;
      end else if (i_int_no_switch) begin
        o_nested_task_flag <= 1'b0;
      end else if (i_flag_write) begin
        o_nested_task_flag <= i_flag_wdata[`PXTS_NT_BIT];
      end
      // machine status word; switch set wins over software clear
      if (i_msw_write) begin
        o_protect_enable_flag <= o_protect_enable_flag | i_msw_wdata[0];
        o_coprocessor_present_flag <= i_msw_wdata[1];
        if (!(ts_go && st_q == ST_RUN && !any_exc))
          o_task_switched_flag <= i_msw_wdata[3];
      end
      if (st_q == ST_SHUT && i_nmi)
        o_addr1 <= 1'b1;
      // -------- pointer tests never fault
      if (i_pt_req) begin
        if (i_pt_op == `PXTS_PT_ADJUST_PRIVILEGE_OP) begin
          o_adj_rpl <= (i_pt_reg_rpl > i_pt_sel_rpl) ?
            i_pt_reg_rpl : i_pt_sel_rpl;
          o_zero_result_flag <= (i_pt_reg_rpl > i_pt_sel_rpl);
        end else
          o_zero_result_flag <= i_pt_permit;
      end
      // -------- real mode high address forcing
      if (i_cs_load)
        o_addr_hi_force <= 1'b0;
    end
  end
endmodule // pxts_ctrl

/* test/pxts_ctrl_props.sv */
/*
 * checker for the exception and task switch controller ports.
 * assumes: bound to pxts_ctrl by name, one clock, reset active low.
 */
`timescale 1ns/10ps
module pxts_props #(
  parameter SEL_W = 16
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_ts_req,
  input wire [1:0] i_ts_src,
  input wire [15:0] i_ts_new_limit,
  input wire [3:0] i_ts_new_type,
  input wire i_pt_req,
  input wire [2:0] i_pt_op,
  input wire i_pt_permit,
  input wire [1:0] i_pt_sel_rpl,
  input wire [1:0] i_pt_reg_rpl,
  input wire i_cs_load,
  input wire o_exc_take,
  input wire [7:0] o_exc_vec,
  input wire o_err_push,
  input wire o_ts_accept,
  input wire o_ts_mark_old_busy,
  input wire o_task_switched_flag,
  input wire o_nested_task_flag,
  input wire o_zero_result_flag,
  input wire [1:0] o_adj_rpl,
  input wire o_shutdown,
  input wire o_halt_cycle,
  input wire o_addr1,
  input wire o_addr_hi_force,
  input wire [15:0] o_cs,
  input wire [15:0] o_ip
);
  // =====================================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  a_fault_code_push: assert property (o_exc_take && o_exc_vec >= 8'h0A &&
    o_exc_vec <= 8'h0D |-> o_err_push) else $error("fault without code");
  a_overrun_no_code: assert property (o_exc_take && o_exc_vec == 8'h09
    |-> !o_err_push) else $error("overrun pushed code");
  a_limit_refused: assert property (i_ce && i_ts_req &&
    i_ts_new_limit <= 16'h002B |=> !o_ts_accept) else $error("short limit");
  a_busy_refused: assert property (i_ce && i_ts_req && i_ts_src != 2'h3 &&
    i_ts_new_type == 4'h3 |=> !o_ts_accept) else $error("busy target");
  a_switch_sets_ts: assert property (o_ts_accept |->
    o_task_switched_flag) else $error("task switched flag clear");
  a_jmp_old_free: assert property (o_ts_accept && $past(i_ts_src) == 2'h0
    |-> !o_ts_mark_old_busy) else $error("jump marked old busy");
  a_call_sets_nt: assert property (o_ts_accept && $past(i_ts_src) == 2'h1
    |-> o_nested_task_flag) else $error("call left nested clear");
  a_ptest_zero: assert property (i_ce && i_pt_req && i_pt_op < 3'h4 &&
    !o_shutdown |=> o_zero_result_flag == $past(i_pt_permit))
    else $error("pointer test zero flag");
  a_adjust_privilege_op_max: assert property (i_ce && i_pt_req && i_pt_op == 3'h4 &&
    !o_shutdown |=> o_zero_result_flag == ($past(i_pt_sel_rpl) <
    $past(i_pt_reg_rpl)) && o_adj_rpl == (($past(i_pt_sel_rpl) >
    $past(i_pt_reg_rpl)) ? $past(i_pt_sel_rpl) : $past(i_pt_reg_rpl)))
    else $error("adjust privilege result");
  a_halt_addr_low: assert property (o_halt_cycle |-> o_shutdown &&
    !o_addr1) else $error("halt cycle address");
  a_force_drops: assert property ($fell(o_addr_hi_force) |->
    $past(i_cs_load)) else $error("address force dropped early");
  a_entry_point: assert property (o_cs == 16'hF000 &&
    o_ip == 16'hFFF0) else $error("reset entry point");
  c_switch: cover property (o_ts_accept);
  c_double: cover property (o_exc_take && o_exc_vec == 8'h08);
  c_halt: cover property (o_halt_cycle);
endmodule // pxts_props

/* test/tb_top.sv */
/*
 * self-checking bench for pxts_ctrl: exceptions, task switches,
 * pointer tests, double fault, shutdown and reset addressing.
 * assumes: design latency of one cycle; inputs change 1 ns after edge.
 */
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk, i_rst_b, i_ce, i_exc_req, i_exc_sel_valid;
  logic i_exc_stack_seg, i_insn_done, i_nmi, i_push_all_op_pop_all_op, i_cpx_op;
  logic i_ts_req, i_ts_gate_is_task, i_int_no_switch, i_flag_write;
  logic i_msw_write, i_pt_req, i_pt_permit, i_cs_load;
  logic [7:0] i_exc_vec;
  logic [15:0] i_exc_sel, i_insn_start_ip, i_next_ip, i_saved_sp;
  logic [15:0] i_ts_new_sel, i_ts_new_limit, i_ts_new_flags, i_flag_wdata;
  logic [23:0] i_ts_new_base;
  logic [3:0] i_ts_new_type, i_msw_wdata, o_ts_new_type;
  logic [1:0] i_ts_src, i_pt_sel_rpl, i_pt_reg_rpl, o_adj_rpl;
  logic [2:0] i_pt_op;
  logic o_exc_take, o_err_push, o_restartable, o_ts_accept, o_ts_save_old;
  logic o_ts_mark_old_busy, o_ts_mark_old_free, o_ts_mark_new_busy;
  logic o_nested_task_flag, o_interrupt_return_op_switch, o_task_switched_flag;
  logic o_coprocessor_present_flag, o_protect_enable_flag;
  logic o_zero_result_flag, o_shutdown, o_halt_cycle, o_addr1;
  logic o_addr_hi_force;
  logic [7:0] o_exc_vec;
  logic [15:0] o_err_code, o_ret_ip, o_back_link, o_task_sel;
  logic [15:0] o_task_limit, o_cs, o_ip;
  logic [23:0] o_task_base;
  logic [43:0] expq[$];
  logic [43:0] e;
  logic [15:0] cur, s;
  integer seed = 32'h3065, bad_count = 0, num_checks = 0, k;
  pxts_ctrl #(.SEL_W(16)) uut (.*);
  // =====================================================
  // checks and report
  task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %s exp %h seen %h", n, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // monitor takes the oldest note whenever an exception is taken
  always @(negedge i_sys_clk) if (o_exc_take === 1'b1) begin
    if (expq.size() == 0) chk("unexpected take", 1, 0);
    else begin
      e = expq.pop_front();
      chk("vec", o_exc_vec, e[43:36]);
      if (e[43:36] !== 8'h07) chk("push", o_err_push, e[35]);
      if (e[35]) chk("code", o_err_code, e[34:19]);
      if (e[18]) chk("restart", o_restartable, e[17]);
      if (e[16]) chk("ret ip", o_ret_ip, e[15:0]);
    end
  end
  // =====================================================
  // drivers
  task tick;
    begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask
  task exc(input [7:0] v, input stk, input sv, input [7:0] ev,
    input [1:0] rc);
    logic [15:0] ip;
    begin
      s = $random(seed);
      ip = $random(seed);
      i_exc_req = 1;
      i_exc_vec = v;
      i_exc_sel = s;
      i_exc_sel_valid = sv;
      i_exc_stack_seg = stk;
      i_insn_start_ip = ip;
      i_next_ip = ip + 16'h0003;
      expq.push_back({ev, ev != 8'h09, (ev == 8'h08 || !sv) ? 16'h0000 : s,
        rc, ev != 8'h08, ev == 8'h09 ? ip + 16'h0003 : ip});
      tick;
      i_exc_req = 0;
    end
  endtask
  task pulse(input integer w);
    begin
      case (w)
        0: i_insn_done = 1;
        1: i_nmi = 1;
        2: i_cpx_op = 1;
        3: i_int_no_switch = 1;
        4: i_cs_load = 1;
        5: i_exc_req = 1;
        6: i_flag_write = 1;
        default: i_msw_write = 1;
      endcase
      tick;
      {i_insn_done, i_nmi, i_cpx_op, i_int_no_switch} = 4'h0;
      {i_cs_load, i_exc_req, i_flag_write, i_msw_write} = 4'h0;
    end
  endtask
  task tsw(input [1:0] src, input g, input [15:0] lim, input [3:0] ty);
    begin
      s = $random(seed);
      {i_ts_req, i_ts_src, i_ts_gate_is_task, i_ts_new_sel} = {1'b1, src, g, s};
      i_ts_new_limit = lim;
      i_ts_new_type = ty;
      i_ts_new_base = $random(seed);
      tick;
      i_ts_req = 0;
    end
  endtask
  // =====================================================
  // main sequence
  initial begin
    i_sys_clk = 0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    {i_rst_b, i_exc_req, i_exc_sel_valid, i_exc_stack_seg, i_insn_done} = 0;
    {i_nmi, i_push_all_op_pop_all_op, i_cpx_op, i_ts_req, i_ts_gate_is_task} = 0;
    {i_int_no_switch, i_flag_write, i_msw_write, i_pt_req} = 0;
    {i_pt_permit, i_cs_load, i_exc_vec, i_exc_sel, i_insn_start_ip} = 0;
    {i_next_ip, i_saved_sp, i_ts_new_sel, i_ts_new_limit} = 0;
    {i_ts_new_flags, i_flag_wdata, i_ts_new_base, i_ts_new_type} = 0;
    {i_msw_wdata, i_ts_src, i_pt_sel_rpl, i_pt_reg_rpl, i_pt_op} = 0;
    i_ce = 1;
    repeat (4) tick;
    i_rst_b = 1;
    chk("force", o_addr_hi_force, 1);
    chk("entry", {o_cs, o_ip}, 32'hF000FFF0);
    i_msw_wdata = 4'h3;
    pulse(7);
    chk("pe", o_protect_enable_flag, 1);
    exc(8'h0A, 0, 1, 8'h0A, 2'b00); pulse(0);
    exc(8'h0B, 0, 1, 8'h0B, 2'b11); pulse(0);
    exc(8'h0B, 1, 1, 8'h0C, 2'b11); pulse(0);
    exc(8'h0D, 0, 0, 8'h0D, 2'b00); pulse(0);
    exc(8'h09, 0, 1, 8'h09, 2'b00); pulse(0);
    i_push_all_op_pop_all_op = 1;
    for (k = 0; k < 5; k = k + 1) begin
      i_saved_sp = k == 4 ? 16'h0100 : (k[1] ? 16'hFFFC : 16'h0000) + k;
      exc(8'h0C, 0, 1, 8'h0C, {1'b1, k == 4}); pulse(0);
    end
    i_push_all_op_pop_all_op = 0;
    $display("test exceptions done");
    exc(8'h0D, 0, 1, 8'h0D, 2'b00);
    exc(8'h0B, 0, 1, 8'h08, 2'b00);
    pulse(5);
    chk("halt", {o_shutdown, o_halt_cycle, o_addr1}, 3'b110);
    pulse(5);
    pulse(1);
    chk("nmi exit", {o_shutdown, o_protect_enable_flag}, 2'b01);
    pulse(0);
    $display("test double fault done");
    i_msw_wdata = 4'hB;
    pulse(7);
    expq.push_back({8'h07, 1'b0, 16'h0000, 3'b000, 16'h0000});
    pulse(2);
    i_msw_wdata = 4'h3;
    pulse(7);
    pulse(2);
    cur = o_task_sel;
    tsw(2'h1, 0, 16'h002C, 4'h1);
    chk("call", {o_ts_accept, o_ts_save_old, o_ts_mark_old_busy,
      o_ts_mark_new_busy, o_nested_task_flag, o_task_switched_flag},
      6'h3F);
    chk("link", o_back_link, cur);
    chk("tr", {o_task_sel, o_task_limit}, {s, 16'h002C});
    chk("base", o_task_base, i_ts_new_base);
    chk("type", o_ts_new_type, 4'h3);
    cur = s;
    tsw(2'h0, 0, 16'hFFFF, 4'h1);
    chk("jmp", {o_ts_accept, o_ts_mark_old_busy}, 2'b10);
    chk("jmp link", o_back_link, cur);
    tsw(2'h0, 0, 16'h002B, 4'h1);
    chk("short", o_ts_accept, 0);
    tsw(2'h2, 0, 16'h0100, 4'h1);
    chk("no gate", o_ts_accept, 0);
    pulse(0);
    tsw(2'h1, 0, 16'h0100, 4'h3);
    expq.push_back({8'h0D, 1'b1, s, 3'b000, 16'h0000});
    chk("busy", o_ts_accept, 0);
    pulse(0);
    pulse(3);
    chk("nt clear", o_nested_task_flag, 0);
    i_flag_wdata = 16'h4000;
    pulse(6);
    chk("nt pop", o_nested_task_flag, 1);
    tsw(2'h2, 1, 16'h0100, 4'h1);
    chk("int", {o_ts_accept, o_ts_mark_old_busy}, 2'b11);
    $display("test task switch done");
    for (k = 0; k < 20; k = k + 1) begin
      {i_pt_permit, i_pt_sel_rpl, i_pt_reg_rpl} = $random(seed);
      i_pt_op = k % 5;
      i_pt_req = 1;
      tick;
      i_pt_req = 0;
      if (i_pt_op == 3'h4) begin
        chk("adj", o_adj_rpl, (i_pt_reg_rpl > i_pt_sel_rpl) ?
          i_pt_reg_rpl : i_pt_sel_rpl);
        chk("adj zf", o_zero_result_flag,
          i_pt_reg_rpl > i_pt_sel_rpl);
      end else
        chk("ptest zf", o_zero_result_flag, i_pt_permit);
    end
    pulse(4);
    chk("force off", o_addr_hi_force, 0);
    for (k = 0; k < 8 && expq.size() != 0; k = k + 1) tick;
    if (expq.size() != 0) chk("missing take", expq.size(), 0);
    $display("test pointer and reset addressing done");
    final_report;
  end
endmodule // tb_top
bind pxts_ctrl pxts_props #(.SEL_W(SEL_W)) u_props (.*);
